// *** src/dsr_regs.vh ***
`ifndef DSR_REGS_VH
`define DSR_REGS_VH
`define DSR_RESULT_W 12
`define DSR_CNT_W 6
`define DSR_LEAD_BITS 6'h02
`define DSR_FIRST_END 6'h0e
`define DSR_SLOT_LEN 6'h10
`define DSR_SECOND_END 6'h1e
`define DSR_FRAME_END 6'h20
`define DSR_ZERO_RESULT 12'h000
`endif

// *** src/dsr_buf2.v ***
`timescale 1ns/1ps
`default_nettype none
module dsr_buf2 #(
  parameter W = 24
) (
  input wire sys_clk_in,
  input wire reset_n_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [W-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [W-1:0] out_data_out
);
  reg [W-1:0] slot0;
  reg [W-1:0] slot1;
  reg [1:0] count;
  wire push;
  wire pop;
  assign in_ready_out = (count != 2'h2);
  assign out_valid_out = (count != 2'h0);
  assign out_data_out = slot0;
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      slot0 <= {W{1'b0}};
      slot1 <= {W{1'b0}};
      count <= 2'h0;
    end else begin
      if (pop) begin
        slot0 <= (count == 2'h2) ? slot1 : in_data_in;
      end else if (push && count == 2'h0) begin
        slot0 <= in_data_in;
      end
      if (push && ((count == 2'h1 && !pop) || (count == 2'h2))) begin
        slot1 <= in_data_in;
      end
      if (push && !pop) begin
        count <= count + 2'h1;
      end else if (pop && !push) begin
        count <= count - 2'h1;
      end
    end
  end
endmodule // dsr_buf2
`default_nettype wire

// *** src/dsr_readout.v ***
// Overview of operation
// - result bits change on the falling serial clock edge
// - frame starts with two zeros, then 12 result bits msb first
// - both results shift out together on their own pins
// - 16 clocks: two trailing zeros follow the 12 result bits
// - further 16 clocks: other converter's result on the same pin
// - after conversion the sampling stage returns to tracking
// - frame select falling edge samples and starts both conversions
// - serial clock paces both shifting and conversion
// - range input caught when frame select goes low
`timescale 1ns/1ps
`default_nettype none
`include "dsr_regs.vh"
module dsr_readout (
  input wire sys_clk_in,
  input wire reset_n_in,
  input wire frame_sel_n_in,
  input wire serial_clk_in,
  input wire range_sel_in,
  input wire [2:0] channel_pair_select_in,
  input wire result_valid_in,
  output wire result_ready_out,
  input wire [11:0] result_first_in,
  input wire [11:0] result_second_in,
  output reg result_out_first_out,
  output reg result_out_first_oe_n_out,
  output reg result_out_second_out,
  output reg result_out_second_oe_n_out,
  output reg sample_out,
  output reg tracking_out,
  output reg convert_step_out,
  output reg range_double_out,
  output reg [2:0] channel_pair_out
);
  localparam ST_IDLE = 3'b001;
  localparam ST_SHIFT = 3'b010;
  localparam ST_DONE = 3'b100;
  reg [2:0] state;
  reg [2:0] next_state;
  reg cs_s1;
  reg cs_s2;
  reg cs_s3;
  reg sck_s1;
  reg sck_s2;
  reg sck_s3;
  reg rng_s1;
  reg rng_s2;
  reg [2:0] chp_s1;
  reg [2:0] chp_s2;
  reg [`DSR_CNT_W-1:0] bit_cnt;
  reg [`DSR_RESULT_W-1:0] shift_first;
  reg [`DSR_RESULT_W-1:0] shift_second;
  reg [`DSR_RESULT_W-1:0] hold_first;
  reg [`DSR_RESULT_W-1:0] hold_second;
  wire cs_fall = cs_s3 & ~cs_s2;
  wire cs_rise = ~cs_s3 & cs_s2;
  wire sck_fall = sck_s3 & ~sck_s2;
  // slot index the coming fall drives, cut to the counter width
  wire [`DSR_CNT_W-1:0] slot;
  wire in_lead;
  wire in_first;
  wire in_gap;
  wire in_second;
  assign slot = bit_cnt + 6'h01;
  assign in_lead = (slot < `DSR_LEAD_BITS);
  assign in_first = (slot < `DSR_FIRST_END);
  assign in_gap = (slot < `DSR_SLOT_LEN + `DSR_LEAD_BITS);
  assign in_second = (slot < `DSR_SECOND_END);
  wire buf_valid;
  wire [2*`DSR_RESULT_W-1:0] buf_data;
  // buffer keeps a finished result until a frame takes it
  wire take = buf_valid & cs_fall;
  dsr_buf2 #(.W(2*`DSR_RESULT_W)) u_buf (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(result_valid_in),
    .in_ready_out(result_ready_out),
    .in_data_in({result_first_in, result_second_in}),
    .out_valid_out(buf_valid),
    .out_ready_in(take),
    .out_data_out(buf_data)
  );
  // pins pass two flops before use; third stage is edge history only
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      sck_s1 <= 1'b1;
      sck_s2 <= 1'b1;
      sck_s3 <= 1'b1;
      rng_s1 <= 1'b0;
      rng_s2 <= 1'b0;
      chp_s1 <= 3'h0;
      chp_s2 <= 3'h0;
    end else begin
      cs_s1 <= frame_sel_n_in;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      sck_s1 <= serial_clk_in;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      rng_s1 <= range_sel_in;
      rng_s2 <= rng_s1;
      chp_s1 <= channel_pair_select_in;
      chp_s2 <= chp_s1;
    end
  end
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (cs_fall) begin
          next_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (cs_rise) begin
          next_state = ST_IDLE;
        end else if (sck_fall && bit_cnt == `DSR_FRAME_END - 6'h01) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        if (cs_rise) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= ST_IDLE;
      bit_cnt <= {`DSR_CNT_W{1'b0}};
      shift_first <= `DSR_ZERO_RESULT;
      shift_second <= `DSR_ZERO_RESULT;
      hold_first <= `DSR_ZERO_RESULT;
      hold_second <= `DSR_ZERO_RESULT;
      result_out_first_out <= 1'b0;
      result_out_second_out <= 1'b0;
      result_out_first_oe_n_out <= 1'b1;
      result_out_second_oe_n_out <= 1'b1;
      sample_out <= 1'b0;
      tracking_out <= 1'b1;
      convert_step_out <= 1'b0;
      range_double_out <= 1'b0;
      channel_pair_out <= 3'h0;
    end else begin
      state <= next_state;
      sample_out <= 1'b0;
      convert_step_out <= 1'b0;
      if (state == ST_IDLE && cs_fall) begin
        sample_out <= 1'b1;
        tracking_out <= 1'b0;
        range_double_out <= rng_s2;
        channel_pair_out <= chp_s2;
        bit_cnt <= {`DSR_CNT_W{1'b0}};
        if (buf_valid) begin
          shift_first <= buf_data[2*`DSR_RESULT_W-1:`DSR_RESULT_W];
          shift_second <= buf_data[`DSR_RESULT_W-1:0];
          hold_first <= buf_data[2*`DSR_RESULT_W-1:`DSR_RESULT_W];
          hold_second <= buf_data[`DSR_RESULT_W-1:0];
        end else begin
          // nothing new buffered: resend the last result, not spent zeros
          shift_first <= hold_first;
          shift_second <= hold_second;
        end
        // first leading zero drives as soon as the frame opens
        result_out_first_out <= 1'b0;
        result_out_second_out <= 1'b0;
        result_out_first_oe_n_out <= 1'b0;
        result_out_second_oe_n_out <= 1'b0;
      end else if (state == ST_SHIFT && cs_rise) begin
        result_out_first_oe_n_out <= 1'b1;
        result_out_second_oe_n_out <= 1'b1;
        // park data low so a released pin never holds a stale bit
        result_out_first_out <= 1'b0;
        result_out_second_out <= 1'b0;
        tracking_out <= 1'b1;
      end else if (state == ST_DONE && cs_rise) begin
        result_out_first_oe_n_out <= 1'b1;
        result_out_second_oe_n_out <= 1'b1;
        result_out_first_out <= 1'b0;
        result_out_second_out <= 1'b0;
      end else if (state == ST_SHIFT && sck_fall) begin
        bit_cnt <= bit_cnt + 6'h01;
        convert_step_out <= 1'b1;
        if (bit_cnt == `DSR_FIRST_END - 6'h01) begin
          tracking_out <= 1'b1;
        end
        if (in_lead) begin
          result_out_first_out <= 1'b0;
          result_out_second_out <= 1'b0;
        end else if (in_first) begin
          result_out_first_out <= shift_first[`DSR_RESULT_W-1];
          result_out_second_out <= shift_second[`DSR_RESULT_W-1];
          shift_first <= {shift_first[`DSR_RESULT_W-2:0], 1'b0};
          shift_second <= {shift_second[`DSR_RESULT_W-2:0], 1'b0};
        end else if (in_gap) begin
          result_out_first_out <= 1'b0;
          result_out_second_out <= 1'b0;
          // reload crossed results for the extended frame
          shift_first <= hold_second;
          shift_second <= hold_first;
        end else if (in_second) begin
          result_out_first_out <= shift_first[`DSR_RESULT_W-1];
          result_out_second_out <= shift_second[`DSR_RESULT_W-1];
          shift_first <= {shift_first[`DSR_RESULT_W-2:0], 1'b0};
          shift_second <= {shift_second[`DSR_RESULT_W-2:0], 1'b0};
        end else begin
          result_out_first_out <= 1'b0;
          result_out_second_out <= 1'b0;
        end
      end
    end
  end
endmodule // dsr_readout
`default_nettype wire

// *** dv/dsr_chk_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module dsr_chk (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic frame_sel_n_in,
  input wire logic serial_clk_in,
  input wire logic range_sel_in,
  input wire logic [2:0] channel_pair_select_in,
  input wire logic result_out_first_out,
  input wire logic result_out_first_oe_n_out,
  input wire logic result_out_second_out,
  input wire logic result_out_second_oe_n_out,
  input wire logic sample_out,
  input wire logic tracking_out,
  input wire logic convert_step_out,
  input wire logic range_double_out,
  input wire logic [2:0] channel_pair_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  frame_start_a: assert property ($fell(frame_sel_n_in)
    |-> ##[1:5] sample_out) else $error("no sample");
  sample_state_a: assert property (sample_out |->
    !frame_sel_n_in && !tracking_out && !result_out_first_oe_n_out
    && !result_out_first_out && !result_out_second_out) else $error("start");
  range_take_a: assert property (sample_out |=>
    range_double_out == $past(range_sel_in) &&
    channel_pair_out == $past(channel_pair_select_in)) else $error("range");
  range_hold_a: assert property ($changed({range_double_out,
    channel_pair_out}) |-> sample_out || $past(sample_out)) else $error("hold");
  pin_release_a: assert property (frame_sel_n_in[*8] |->
    result_out_first_oe_n_out && result_out_second_oe_n_out) else $error("oe");
  fall_shift_a: assert property ((serial_clk_in && !frame_sel_n_in)[*8]
    |-> $stable(result_out_first_out) && $stable(result_out_second_out))
    else $error("shift");
  track_hold_a: assert property (sample_out |-> !tracking_out[*8])
    else $error("track");
  step_pulse_a: assert property (convert_step_out |->
    !frame_sel_n_in ##1 !convert_step_out) else $error("step");
  pins_pair_a: assert property (result_out_first_oe_n_out ==
    result_out_second_oe_n_out) else $error("pins");
endmodule // dsr_chk
`default_nettype wire

// *** dv/dsr_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module dsr_host (
  input wire logic clk_in,
  input wire logic data_a_in,
  input wire logic data_b_in,
  output logic frame_n_out,
  output logic sclk_out
);
  logic [31:0] got_a;
  logic [31:0] got_b;
  // clock stands high between frames
  initial begin
    frame_n_out = 1'b1;
    sclk_out = 1'b1;
  end
  // sample late in the high half, well clear of the shifting fall
  task automatic frame(input int n);
    got_a = 32'h0;
    got_b = 32'h0;
    frame_n_out = 1'b0;
    repeat (8) @(negedge clk_in);
    for (int i = 0; i < n; i++) begin
      got_a = {got_a[30:0], data_a_in};
      got_b = {got_b[30:0], data_b_in};
      sclk_out = 1'b0;
      repeat (8) @(negedge clk_in);
      sclk_out = 1'b1;
      repeat (8) @(negedge clk_in);
    end
    frame_n_out = 1'b1;
  endtask
endmodule // dsr_host
`default_nettype wire

// *** dv/dual_adc_serial_readout_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module dual_adc_serial_readout_tb;
  logic clk = 1'b0, rst_n = 1'b0, rng = 1'b0, vld = 1'b0;
  logic fs_n, sclk, rdy, da, db, ea, eb, trk, rd;
  logic [2:0] pair = 3'h0, cp;
  logic [11:0] ra = 12'h000, rb = 12'h000;
  logic [23:0] q[$], last = 24'h0;
  logic [31:0] seed = 32'ha80e543a;
  int n_mismatch = 0, checked = 0, cyc = 0;
  initial forever #20 clk = ~clk;
  dsr_readout dut_u (.sys_clk_in(clk), .reset_n_in(rst_n),
    .frame_sel_n_in(fs_n), .serial_clk_in(sclk), .range_sel_in(rng),
    .channel_pair_select_in(pair), .result_valid_in(vld),
    .result_ready_out(rdy), .result_first_in(ra), .result_second_in(rb),
    .result_out_first_out(da), .result_out_first_oe_n_out(ea),
    .result_out_second_out(db), .result_out_second_oe_n_out(eb),
    .sample_out(), .tracking_out(trk), .convert_step_out(),
    .range_double_out(rd), .channel_pair_out(cp));
  // a released pin reads inverted, so sampling it off-frame shows up
  dsr_host host_u (.clk_in(clk), .data_a_in(ea ? ~da : da),
    .data_b_in(eb ? ~db : db), .frame_n_out(fs_n), .sclk_out(sclk));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [31:0] ex(input logic [23:0] w, input int n);
    return {2'h0, w[23:12], 4'h0, w[11:0], 2'h0} >> (32 - n);
  endfunction
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic push(input logic [23:0] w);
    @(negedge clk);
    {ra, rb} = w;
    vld = 1'b1;
    while (rdy !== 1'b1) @(negedge clk);
    q.push_back(w);
    @(negedge clk);
    vld = 1'b0;
    seed = xs(seed);
  endtask
  task automatic run(input int n);
    logic [2:0] p;
    logic r;
    if (q.size() > 0) last = q.pop_front();
    seed = xs(seed);
    p = seed[3:1];
    r = seed[0];
    pair = p;
    rng = r;
    repeat (4) @(negedge clk);
    fork
      host_u.frame(n);
      begin repeat (20) @(negedge clk); rng = ~r; pair = ~p; end
    join
    repeat (8) @(negedge clk);
    chk(rd === r && cp === p, "range");
    chk(host_u.got_a === ex(last, n), "pin a");
    chk(host_u.got_b === ex({last[11:0], last[23:12]}, n), "pin b");
    chk(ea === 1'b1 && eb === 1'b1, "release");
    if (n >= 14) chk(trk === 1'b1, "track");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 12000) begin
      n_mismatch++;
      $display("[FAIL] %0t timeout", $time);
      results();
    end
  end
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(ea === 1'b1 && trk === 1'b1, "idle");
    // host stalls while the buffer fills
    while (rdy === 1'b1 && q.size() < 4)
      push(q.size() ? seed[23:0] : 24'hfff001);
    chk(rdy === 1'b0, "full");
    while (q.size() > 0) run(32);
    run(16);
    for (int k = 0; k < 6; k++) begin
      push(k == 1 ? 24'h800000 : seed[23:0]);
      run(k == 0 ? 14 : k == 1 ? 8 : 32);
    end
    results();
  end
endmodule // dual_adc_serial_readout_tb
bind dsr_readout dsr_chk chk_u (.*);
`default_nettype wire
